// ===== design/qdc_core.sv
`timescale 1ns/100ps
module qdc_core
    import qdc_pkg::*;
(
    input  logic              clk,                      // Core clock
    input  logic              nrst,                     // Async reset, active low
    input  logic              clk_en,                   // Freezes all state when low
    input  logic              sclk,                     // Serial clock pin
    input  logic              cs_n,                     // Chip select pin, active low
    input  logic              sdi,                      // Serial data pin
    input  logic              latch_load_strobe_n,      // Load strobe pin, active low
    input  logic              hw_reset_n,               // Hardware reset pin, active low
    input  logic              group_a_polarity_select,  // High: channels 0,1 unipolar
    input  logic              group_b_polarity_select,  // High: channels 2,3 unipolar
    output logic [3:0]        gain_x4,                  // Per-channel gain select
    output logic [3:0]        chan_bipolar,             // Per-channel mode
    output logic [3:0][15:0]  latch_code,               // Output latch contents
    output logic [3:0][15:0]  corrected_code            // Corrected output codes
);
    // Channel count is fixed by the converter
    localparam int unsigned NCH = 4;

    // Synchronisers: stage one feeds stage two only
    // Every pin is async to clk, so each one costs two cycles of latency;
    // the serial pins share one chain so their relative timing is kept
    logic [6:0] sync1_q, sync1_d;   // First stage
    logic [6:0] sync2_q, sync2_d;   // Second stage, safe to read
    logic       sclk_prev_q, sclk_prev_d;  // Edge detect history
    logic       latch_load_strobe_n_prev_q, latch_load_strobe_n_prev_d;  // Edge detect history

    // Named views of the synchronised pins
    logic sclk_s;
    logic cs_n_s;
    logic sdi_s;
    logic latch_load_strobe_n_n_s;
    logic hw_rst_n_s;
    logic pol_a_s;
    logic pol_b_s;

    // Frame receiver
    qdc_state_e  state_q, state_d;   // Receiver state
    logic [23:0] shift_q, shift_d;   // Serial shift register
    logic [4:0]  cnt_q,   cnt_d;     // Falling edges seen, saturating
    logic        commit;             // Complete write frame at chip select rise

    // Control
    logic [3:0]  gain_sel_q, gain_sel_d;   // Gain select bits
    logic        soft_rst_q, soft_rst_d;   // Software reset, one cycle wide
    logic [3:0]  pend_q, pend_d;           // Input written since last load
    logic        rst_all;                  // Either reset in force
    logic        sclk_fall;                // Falling serial clock seen
    logic        latch_load_strobe_n_fall;                // Falling load strobe seen
    logic        load_all;                 // Broadcast latch load
    logic        cmd_write;                // Frame targets command word
    logic [3:0]  addr;                     // Frame address field
    logic [15:0] data;                     // Frame data field
    logic [3:0]  sel_input;                // Input register write per channel
    logic [3:0]  sel_gain;                 // Gain register write per channel
    logic [3:0]  sel_zero;                 // Zero register write per channel
    logic [3:0]  load;                     // Latch reload per channel

    // One carrier per channel; the channel module owns all its state but the pending flag, kept in pend_q
    qdc_chan_if cif [NCH] ();

    // One-hot channel select from an address window of four
    // Addresses outside the window give an all-zero select
    function automatic logic [3:0] chan_sel(input logic [3:0] a, input logic [3:0] base,
                                            input logic en);
        logic [3:0] s;
        s = 4'h0;
        if (en && (a[3:2] == base[3:2]))
            s[a[1:0]] = 1'b1;
        return s;
    endfunction

    assign sclk_s     = sync2_q[0];
    assign cs_n_s     = sync2_q[1];
    assign sdi_s      = sync2_q[2];
    assign latch_load_strobe_n_n_s   = sync2_q[3];
    assign hw_rst_n_s = sync2_q[4];
    assign pol_a_s    = sync2_q[5];
    assign pol_b_s    = sync2_q[6];

    // Sync chain next values; strobes and serial pins share the same delay
    // Serial clock must stay high and low for three clk cycles at least,
    // or an edge is lost; that bounds the host's rate, not the frame logic
    always_comb
    begin
        sync1_d     = {group_b_polarity_select, group_a_polarity_select, hw_reset_n,
                       latch_load_strobe_n, sdi, cs_n, sclk};
        sync2_d     = sync1_q;
        sclk_prev_d = sclk_s;
        latch_load_strobe_n_prev_d = latch_load_strobe_n_n_s;
    end

    // Sync chain registers; idle pin levels at reset avoid false edges
    // With the clock enable low the chains hold too; pin edges then are lost
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sync1_q     <= 7'h1B;
            sync2_q     <= 7'h1B;
            sclk_prev_q <= 1'b1;
            latch_load_strobe_n_prev_q <= 1'b1;
        end
        else if (clk_en)
        begin
            sync1_q     <= sync1_d;
            sync2_q     <= sync2_d;
            sclk_prev_q <= sclk_prev_d;
            latch_load_strobe_n_prev_q <= latch_load_strobe_n_prev_d;
        end
    end

    // Both resets end in the same synchronous clear; only nrst is async
    // Edges are found on synchronised copies, never on raw pins
    assign rst_all   = !hw_rst_n_s || soft_rst_q;
    assign sclk_fall = sclk_prev_q && !sclk_s;
    assign latch_load_strobe_n_fall = latch_load_strobe_n_prev_q && !latch_load_strobe_n_n_s;
    assign addr      = shift_q[ADDR_HI:ADDR_LO];
    assign data      = shift_q[DATA_HI:DATA_LO];

    // Frame receiver next state
    // The count saturates at the frame length, so an over-long frame still
    // commits with the last 24 bits standing in the shift register
    always_comb
    begin
        state_d = state_q;
        shift_d = shift_q;
        cnt_d   = cnt_q;
        commit  = 1'b0;
        if (rst_all)
        begin
            // Serial pins are not looked at while reset holds
            state_d = ST_IDLE;
            cnt_d   = CNT_RESET;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (!cs_n_s)
                    begin
                        state_d = ST_FRAME;
                        cnt_d   = CNT_RESET;
                    end
                end
                ST_FRAME:
                begin
                    if (cs_n_s)
                    begin
                        // Exactly the frame length, or more with the count held
                        // Short frames drop; read frames have no target here
                        commit  = (cnt_q == FRAME_LAST) && !shift_q[RW_POS];
                        state_d = ST_IDLE;
                    end
                    else if (sclk_fall)
                    begin
                        // Longer frames keep the last 24 bits
                        shift_d = {shift_q[FRAME_BITS-2:0], sdi_s};
                        if (cnt_q != FRAME_LAST)
                            cnt_d = cnt_q + 5'h01;
                    end
                end
            endcase
        end
    end

    // Frame receiver registers
    // Shift contents are not cleared between frames; only the count matters
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_q <= ST_IDLE;
            shift_q <= 24'h00_0000;
            cnt_q   <= CNT_RESET;
        end
        else if (clk_en)
        begin
            state_q <= state_d;
            shift_q <= shift_d;
            cnt_q   <= cnt_d;
        end
    end

    // Decode of a committed frame and latch load control
    // Gain selects are rewritten by every command frame, so the host must
    // send the full set of gain bits along with a load or reset request
    // Strobe fall and load bit are one broadcast and need no priority
    always_comb
    begin
        cmd_write  = commit && (addr == ADDR_CMD);
        sel_input  = chan_sel(addr, ADDR_INPUT_BASE, commit);
        sel_zero   = chan_sel(addr, ADDR_ZERO_BASE, commit);
        sel_gain   = chan_sel(addr, ADDR_GAIN_BASE, commit);
        load_all   = !rst_all && (latch_load_strobe_n_fall || (cmd_write && data[CMD_LD_POS]));
        gain_sel_d = gain_sel_q;
        soft_rst_d = 1'b0;
        pend_d     = pend_q;
        load       = 4'h0;
        if (rst_all)
        begin
            gain_sel_d = GAIN_SEL_RESET;
            pend_d     = 4'h0;
        end
        else
        begin
            if (cmd_write)
            begin
                gain_sel_d = data[CMD_GAIN_LO+3:CMD_GAIN_LO];
                soft_rst_d = data[CMD_RST_POS];
            end
            for (int i = 0; i < NCH; i++)
            begin
                // Direct update when the strobe is low at frame end
                // A write meeting a broadcast load is loaded at once, so the
                // pending flag never has to win against its own clear
                load[i] = (pend_q[i] && load_all)
                        || (sel_input[i] && (!latch_load_strobe_n_n_s || load_all));
                if (sel_input[i] && !load[i])
                    pend_d[i] = 1'b1;
                else if (load[i])
                    pend_d[i] = 1'b0;
            end
        end
    end

    // Control registers
    // Software reset lasts one cycle; the clear it causes lands one cycle
    // after the command frame commits
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            gain_sel_q <= GAIN_SEL_RESET;
            soft_rst_q <= 1'b0;
            pend_q     <= 4'h0;
        end
        else if (clk_en)
        begin
            gain_sel_q <= gain_sel_d;
            soft_rst_q <= soft_rst_d;
            pend_q     <= pend_d;
        end
    end

    // Four channels; group A is 0 and 1, group B is 2 and 3
    // Polarity is read live, but a pin change reaches the corrected code
    // only at the next load, since correction runs at load time alone
    for (genvar g = 0; g < NCH; g++)
    begin : g_ch
        assign cif[g].clear    = rst_all;
        assign cif[g].wr_input = sel_input[g];
        assign cif[g].wr_gain  = sel_gain[g];
        assign cif[g].wr_zero  = sel_zero[g];
        assign cif[g].load     = load[g];
        assign cif[g].data     = data;
        assign cif[g].bipolar  = (g < 2) ? !pol_a_s : !pol_b_s;
        assign latch_code[g]     = cif[g].latch_code;
        assign corrected_code[g] = cif[g].corrected;
        assign chan_bipolar[g]   = cif[g].bipolar;

        qdc_chan i_qdc_chan
        (
            .clk    (clk),
            .nrst   (nrst),
            .clk_en (clk_en),
            .bus    (cif[g])
        );
    end

    // Gain selects drive the output stage switches directly
    assign gain_x4 = gain_sel_q;
endmodule

// ===== design/qdc_pkg.sv
package qdc_pkg;
    // Serial frame layout
    localparam int unsigned FRAME_BITS  = 24;
    localparam int unsigned RW_POS      = 23;
    localparam int unsigned ADDR_HI     = 22;
    localparam int unsigned ADDR_LO     = 19;
    localparam int unsigned DATA_HI     = 18;
    localparam int unsigned DATA_LO     = 3;
    localparam logic [4:0]  FRAME_LAST  = 5'h18;
    localparam logic [4:0]  CNT_RESET   = 5'h00;

    // Register address decode
    localparam logic [3:0]  ADDR_CMD        = 4'h0;
    localparam logic [3:0]  ADDR_INPUT_BASE = 4'h4;
    localparam logic [3:0]  ADDR_ZERO_BASE  = 4'h8;
    localparam logic [3:0]  ADDR_GAIN_BASE  = 4'hC;

    // Command word fields
    localparam int unsigned CMD_LD_POS  = 0;
    localparam int unsigned CMD_RST_POS = 1;
    localparam int unsigned CMD_GAIN_LO = 2;
    localparam logic [3:0]  GAIN_SEL_RESET = 4'hF;

    // Channel code widths and reset values
    localparam int unsigned CODE_W      = 16;
    localparam int unsigned GAIN_CODE_W = 8;
    localparam int unsigned ZERO_CODE_W = 9;
    localparam logic [15:0] CODE_RESET  = 16'h0000;
    localparam logic [7:0]  GAIN_CODE_RESET = 8'h00;
    localparam logic [8:0]  ZERO_CODE_RESET = 9'h000;

    // Correction arithmetic: unity factors and shifts (incl. 1/8 LSB zero weight)
    localparam logic signed [18:0] UNITY_BIP = 19'sh2_0000;
    localparam logic signed [18:0] UNITY_UNI = 19'sh1_0000;
    localparam int unsigned SHIFT_BIP   = 20;
    localparam int unsigned SHIFT_UNI   = 19;
    localparam logic signed [39:0] BIP_MAX = 40'sh00_0000_7FFF;
    localparam logic signed [39:0] BIP_MIN = -40'sh00_0000_8000;
    localparam logic signed [39:0] UNI_MAX = 40'sh00_0000_FFFF;

    // Frame receiver states
    typedef enum logic [1:0]
    {
        ST_IDLE  = 2'b01,
        ST_FRAME = 2'b10
    } qdc_state_e;
endpackage

// ===== design/qdc_chan_if.sv
`timescale 1ns/100ps
interface qdc_chan_if;
    logic        clear;          // Synchronous clear from either reset
    logic        wr_input;       // Write input register
    logic        wr_gain;        // Write gain correction
    logic        wr_zero;        // Write zero correction
    logic        load;           // Reload output latch
    logic        bipolar;        // Group mode for this channel
    logic [15:0] data;           // Frame data field
    logic [15:0] latch_code;     // Output latch content
    logic [15:0] corrected;      // Corrected output code

    modport ctrl (output clear, wr_input, wr_gain, wr_zero, load, bipolar, data,
                  input latch_code, corrected);
    modport chan (input clear, wr_input, wr_gain, wr_zero, load, bipolar, data,
                  output latch_code, corrected);
endinterface

// ===== design/qdc_chan.sv
`timescale 1ns/100ps
module qdc_chan
    import qdc_pkg::*;
(
    input  logic       clk,
    input  logic       nrst,
    input  logic       clk_en,
    qdc_chan_if.chan   bus
);
    logic [15:0] input_q, input_d;     // Input register
    logic [15:0] latch_q, latch_d;     // Output latch
    logic [7:0]  gain_q,  gain_d;      // Gain correction code
    logic [8:0]  zero_q,  zero_d;      // Zero correction code
    logic [15:0] corr_q,  corr_d;      // Corrected code

    // Clamp a scaled result to the legal range of the active code format
    function automatic logic [15:0] sat_code(input logic signed [39:0] x, input logic bip);
        logic [15:0] r;
        r = x[15:0];
        if (bip)
        begin
            if (x > BIP_MAX)
                r = BIP_MAX[15:0];
            else if (x < BIP_MIN)
                r = BIP_MIN[15:0];
        end
        else
        begin
            if (x > UNI_MAX)
                r = UNI_MAX[15:0];
            else if (x < 40'sh0)
                r = CODE_RESET;
        end
        return r;
    endfunction

    // Apply zero (1/8 LSB steps) then gain (scale by mode) to a latched code
    function automatic logic [15:0] correct(input logic [15:0] code, input logic [7:0] g,
                                           input logic [8:0] z, input logic bip);
        logic signed [20:0] v;
        logic signed [18:0] k;
        logic signed [39:0] p;
        v = bip ? {{2{code[15]}}, code, 3'b000} : {2'b00, code, 3'b000};
        v = v + {{12{z[8]}}, z};
        k = (bip ? UNITY_BIP : UNITY_UNI) + {{11{g[7]}}, g};
        p = 40'(v) * 40'(k);
        p = bip ? (p >>> SHIFT_BIP) : (p >>> SHIFT_UNI);
        return sat_code(p, bip);
    endfunction

    // Next values of all channel state
    always_comb
    begin
        input_d = input_q;
        latch_d = latch_q;
        gain_d  = gain_q;
        zero_d  = zero_q;
        corr_d  = corr_q;
        if (bus.clear)
        begin
            input_d = CODE_RESET;
            latch_d = CODE_RESET;
            gain_d  = GAIN_CODE_RESET;
            zero_d  = ZERO_CODE_RESET;
            corr_d  = CODE_RESET;
        end
        else
        begin
            if (bus.wr_input)
                input_d = bus.data;
            if (bus.wr_gain)
                gain_d = bus.data[GAIN_CODE_W-1:0];
            if (bus.wr_zero)
                zero_d = bus.data[ZERO_CODE_W-1:0];
            if (bus.load)
            begin
                // Fresh data bypasses the input register in direct update
                latch_d = bus.wr_input ? bus.data : input_q;
                corr_d  = correct(latch_d, gain_q, zero_q, bus.bipolar);
            end
        end
    end

    // Channel registers
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            input_q <= CODE_RESET;
            latch_q <= CODE_RESET;
            gain_q  <= GAIN_CODE_RESET;
            zero_q  <= ZERO_CODE_RESET;
            corr_q  <= CODE_RESET;
        end
        else if (clk_en)
        begin
            input_q <= input_d;
            latch_q <= latch_d;
            gain_q  <= gain_d;
            zero_q  <= zero_d;
            corr_q  <= corr_d;
        end
    end

    assign bus.latch_code = latch_q;
    assign bus.corrected  = corr_q;
endmodule

// ===== tb/qdc_core_monitor.sv
`timescale 1ns/100ps
module qdc_core_monitor
    import qdc_pkg::*;
(
    input logic             clk,
    input logic             nrst,
    input logic             clk_en,
    input logic             sclk,
    input logic             cs_n,
    input logic             sdi,
    input logic             latch_load_strobe_n,
    input logic             hw_reset_n,
    input logic             group_a_polarity_select,
    input logic             group_b_polarity_select,
    input logic [3:0]       gain_x4,
    input logic [3:0]       chan_bipolar,
    input logic [3:0][15:0] latch_code,
    input logic [3:0][15:0] corrected_code
);
    // One domain, so clock and reset are given once
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    // Gain selects come out of reset at x4
    property p_gain_reset;
        $rose(nrst) |-> gain_x4 == GAIN_SEL_RESET;
    endproperty
    // Pin change reaches the mode after the two-stage sync
    property p_pol_a;
        $changed(group_a_polarity_select) |->
            ##2 chan_bipolar[1:0] == {2{!$past(group_a_polarity_select, 2)}};
    endproperty
    property p_pol_b;
        $changed(group_b_polarity_select) |->
            ##2 chan_bipolar[3:2] == {2{!$past(group_b_polarity_select, 2)}};
    endproperty
    // Held hardware reset clears latches and gain
    property p_hw_clear;
        (!hw_reset_n) [*5] |-> latch_code == '0 && gain_x4 == GAIN_SEL_RESET;
    endproperty
    // Nothing gets through while hardware reset is held
    property p_hw_ignore;
        (!hw_reset_n) [*5] |-> corrected_code == '0;
    endproperty
    // Latch codes stay at zero just after release
    property p_hold_zero;
        $rose(hw_reset_n) |-> (latch_code == '0) [*8];
    endproperty
    // No frame and no strobe: the latches must not move
    property p_quiet;
        (cs_n && latch_load_strobe_n && hw_reset_n) [*8] |-> $stable(latch_code);
    endproperty
    // Gain selects only move on a command frame
    property p_gain_quiet;
        (cs_n && hw_reset_n) [*8] |-> $stable(gain_x4);
    endproperty

    a_gain_reset: assert property (p_gain_reset)
        else $error("gain select wrong after reset");
    a_pol_a: assert property (p_pol_a)
        else $error("group a mode wrong");
    a_pol_b: assert property (p_pol_b)
        else $error("group b mode wrong");
    a_hw_clear: assert property (p_hw_clear)
        else $error("hardware reset did not clear");
    a_hw_ignore: assert property (p_hw_ignore)
        else $error("output moved in hardware reset");
    a_hold_zero: assert property (p_hold_zero)
        else $error("latch left zero after reset");
    a_quiet: assert property (p_quiet)
        else $error("latch moved without cause");
    a_gain_quiet: assert property (p_gain_quiet)
        else $error("gain select moved without command");

    c_strobe: cover property ($fell(latch_load_strobe_n));
    c_hw_reset: cover property ($fell(hw_reset_n));
    c_latch_move: cover property (!$stable(latch_code));
endmodule

bind qdc_core qdc_core_monitor i_qdc_core_monitor (
    .clk                     (clk),
    .nrst                    (nrst),
    .clk_en                  (clk_en),
    .sclk                    (sclk),
    .cs_n                    (cs_n),
    .sdi                     (sdi),
    .latch_load_strobe_n     (latch_load_strobe_n),
    .hw_reset_n              (hw_reset_n),
    .group_a_polarity_select (group_a_polarity_select),
    .group_b_polarity_select (group_b_polarity_select),
    .gain_x4                 (gain_x4),
    .chan_bipolar            (chan_bipolar),
    .latch_code              (latch_code),
    .corrected_code          (corrected_code)
);

// ===== tb/qdc_host_model.sv
`timescale 1ns/100ps
module qdc_host_model (
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    // Clock idles high and stands still between frames
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end

    // Sends n bits MSB first; n below 24 makes a short frame
    // Non-blocking updates keep pin changes that land on a clk edge race-free
    task automatic send(input logic [23:0] w, input int n);
        int i;
        cs_n <= 1'b0;
        for (i = 0; i < n; i++)
        begin
            sdi <= w[23 - i];
            #62.5 sclk <= 1'b0;
            #62.5 sclk <= 1'b1;
        end
        #62.5 cs_n <= 1'b1;
        // Released line has no pull, so show something stale-proof
        sdi <= ~sdi;
        #62.5;
    endtask
endmodule

// ===== tb/qdc_core_tb_top.sv
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module qdc_core_tb_top import qdc_pkg::*;;
    logic             clk = 1'b0;
    logic             nrst = 1'b0;
    logic             clk_en = 1'b1;
    logic             latch_load_strobe_n = 1'b1;
    logic             hw_reset_n = 1'b1;
    logic             group_a_polarity_select = 1'b0;
    logic             group_b_polarity_select = 1'b0;
    logic             sclk;
    logic             cs_n;
    logic             sdi;
    logic [3:0]       gain_x4;
    logic [3:0]       chan_bipolar;
    logic [3:0][15:0] latch_code;
    logic [3:0][15:0] corrected_code;
    int               n_mismatch = 0;
    int               cmp_count = 0;
    // Boundary corrections per channel: saturating tops, a signed minimum and a small unipolar code
    logic [15:0]      t_code [4] = '{16'h7FFF, 16'h8000, 16'hFFFF, 16'h0010};
    logic [8:0]       t_zero [4] = '{9'h0FF, 9'h100, 9'h001, 9'h1FF};
    logic [7:0]       t_gain [4] = '{8'h7F, 8'h80, 8'h7F, 8'h80};

    always #2 clk = ~clk;

    qdc_core i_qdc_core (
        .clk                     (clk),
        .nrst                    (nrst),
        .clk_en                  (clk_en),
        .sclk                    (sclk),
        .cs_n                    (cs_n),
        .sdi                     (sdi),
        .latch_load_strobe_n     (latch_load_strobe_n),
        .hw_reset_n              (hw_reset_n),
        .group_a_polarity_select (group_a_polarity_select),
        .group_b_polarity_select (group_b_polarity_select),
        .gain_x4                 (gain_x4),
        .chan_bipolar            (chan_bipolar),
        .latch_code              (latch_code),
        .corrected_code          (corrected_code)
    );

    qdc_host_model i_qdc_host_model (
        .sclk (sclk),
        .cs_n (cs_n),
        .sdi  (sdi)
    );

    // Reference correction: code at x8 plus zero, times unity plus gain
    function automatic logic [15:0] exp_corr(logic [15:0] c, logic [8:0] z,
                                             logic [7:0] g, bit bip);
        longint v;
        longint r;
        v = bip ? longint'($signed(c)) : longint'(c);
        v = v * 8 + longint'($signed(z));
        r = (v * ((bip ? 131072 : 65536) + longint'($signed(g)))) >>> (bip ? 20 : 19);
        // Clamp to the span of the mode
        if (bip)
            r = (r > 32767) ? 32767 : ((r < -32768) ? -32768 : r);
        else
            r = (r > 65535) ? 65535 : ((r < 0) ? 0 : r);
        return r[15:0];
    endfunction

    // One write frame, then room for the sync and commit
    task automatic wr(input logic [3:0] a, input logic [15:0] d, input int n = 24);
        i_qdc_host_model.send({1'b0, a, d, 3'b000}, n);
        repeat (8) @(posedge clk);
    endtask

    task automatic strobe_pulse;
        @(posedge clk) latch_load_strobe_n <= 1'b0;
        repeat (4) @(posedge clk);
        latch_load_strobe_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask

    task automatic summarize;
        $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Hang guard, far beyond the expected run
    initial
    begin
        #200000;
        n_mismatch++;
        summarize();
    end

    initial
    begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(gain_x4, 4'hF)
        `CHK(latch_code, 64'h0)
        // Group B unipolar, deferred load of all four channels
        group_b_polarity_select <= 1'b1;
        repeat (6) @(posedge clk);
        `CHK(chan_bipolar, 4'b0011)
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_ZERO_BASE + 4'(i), {7'h0, t_zero[i]});
            wr(ADDR_GAIN_BASE + 4'(i), {8'h0, t_gain[i]});
            wr(ADDR_INPUT_BASE + 4'(i), t_code[i]);
        end
        `CHK(latch_code, 64'h0)
        strobe_pulse();
        for (int i = 0; i < 4; i++)
        begin
            `CHK(latch_code[i], t_code[i])
            `CHK(corrected_code[i], exp_corr(t_code[i], t_zero[i], t_gain[i], i < 2))
        end
        // Load bit with gain selects in the same command
        wr(ADDR_INPUT_BASE + 4'h1, 16'h00AA);
        `CHK(latch_code[1], 16'h8000)
        wr(ADDR_CMD, 16'h0015);
        `CHK(latch_code[1], 16'h00AA)
        `CHK(latch_code[0], 16'h7FFF)
        `CHK(gain_x4, 4'h5)
        `CHK(corrected_code[1], exp_corr(16'h00AA, 9'h100, 8'h80, 1'b1))
        // Soft reset
        wr(ADDR_CMD, 16'h0002);
        `CHK(gain_x4, 4'hF)
        `CHK(latch_code, 64'h0)
        `CHK(corrected_code, 64'h0)
        group_a_polarity_select <= 1'b1;
        group_b_polarity_select <= 1'b0;
        repeat (6) @(posedge clk);
        `CHK(chan_bipolar, 4'b1100)
        group_a_polarity_select <= 1'b0;
        repeat (6) @(posedge clk);
        // Strobe held low: direct load; short frame dropped
        latch_load_strobe_n <= 1'b0;
        wr(ADDR_INPUT_BASE + 4'h2, 16'h8000);
        `CHK(latch_code[2], 16'h8000)
        `CHK(corrected_code[2], 16'h8000)
        wr(ADDR_INPUT_BASE + 4'h3, 16'h1234, 23);
        `CHK(latch_code[3], 16'h0000)
        // Hardware reset blocks a frame, then service resumes
        hw_reset_n <= 1'b0;
        repeat (8) @(posedge clk);
        wr(ADDR_INPUT_BASE, 16'h0042);
        `CHK(latch_code, 64'h0)
        `CHK(gain_x4, 4'hF)
        hw_reset_n <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK(latch_code, 64'h0)
        wr(ADDR_INPUT_BASE, 16'h0042);
        `CHK(latch_code[0], 16'h0042)
        // Read frame, then a write under a frozen clock enable: ch1 untouched
        i_qdc_host_model.send({1'b1, ADDR_INPUT_BASE + 4'h1, 16'h0055, 3'b000}, 24);
        repeat (8) @(posedge clk);
        `CHK(latch_code[1], 16'h0000)
        clk_en <= 1'b0;
        wr(ADDR_INPUT_BASE + 4'h1, 16'h0077);
        clk_en <= 1'b1;
        repeat (4) @(posedge clk);
        `CHK(latch_code[1], 16'h0000)
        latch_load_strobe_n <= 1'b1;
        summarize();
    end
endmodule
